// file: rx_fifo_flow_control.sv
// rx_fifo_flow_control: automatic receive flow control plus the data and
// command registers of the indirect mac register path.
// assumes a simple synchronous register port (select, write, address),
// a receive fifo byte count and frame classification from the mac.
// Notes on behaviour
// - high threshold in 23:16, 64-byte units
// - full duplex: one pause frame at high
// - half duplex: jam matching frames while high
// - low threshold 15:8; zero pause below it
// - resume only after an actual sent pause
// - transmitter off: no pause, no jam
// - duration code 7:4, unused in full duplex
// - duration table 5us..600us, slow adds 2.2us
// - bit 3 jams multicast frames
// - bit 2 jams broadcast frames
// - bit 1 jams frames to own address
// - bit 0 any frame, full-duplex enable
// - any-frame half duplex reacts on preamble
// - any-frame full duplex requests pause immediately
// - any-frame overrides bits 3:1
// - 32-bit data register, reset zero
// - busy bit starts access until done
// - direction bit: set reads, clear writes
// - 8-bit address selects mac register
`timescale 1ns/1ps
`include "flow_consts.svh"
module rx_fifo_flow_control (
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // receive side status from the mac
  input wire logic [13:0] rx_fifo_bytes,
  input wire logic full_duplex,
  input wire logic slow_link,
  input wire logic tx_enabled,
  input wire logic rx_preamble,
  input wire logic rx_addr_valid,
  input wire logic rx_is_multicast,
  input wire logic rx_is_broadcast,
  input wire logic rx_is_own,
  // pause frame request towards the mac
  output logic pause_req,
  output logic pause_zero,
  input wire logic pause_ack,
  // half-duplex backpressure
  output logic jam,
  // indirect mac register path
  output logic mac_csr_req,
  output logic mac_csr_read,
  output logic [7:0] mac_csr_addr,
  output logic [31:0] mac_csr_wdata,
  input wire logic [31:0] mac_csr_rdata,
  input wire logic mac_csr_done
);
  logic [23:0] cfg; // flow configuration bits 23:0
  logic [23:0] next_cfg;
  logic [31:0] data; // indirect data register
  logic [31:0] next_data;
  logic cmd_dir; // indirect direction, 1 = read
  logic next_cmd_dir;
  logic [7:0] cmd_addr; // indirect target address
  logic [7:0] next_cmd_addr;
  logic [31:0] next_rdata;
  logic wr_cmd; // register write strobes
  logic wr_data;
  logic wr_cfg;
  logic acc_busy; // indirect access in progress
  logic acc_req;
  logic acc_start;
  logic [13:0] hi_bytes; // thresholds in bytes
  logic [13:0] lo_bytes;
  logic at_high;
  logic below_low;
  logic any_frame;
  logic frame_match; // frame meets jam criteria
  logic jam_start;
  logic jam_running;
  flow_pkg::flow_state_t state; // flow machine
  flow_pkg::flow_state_t next_state;
  logic armed; // high excursion may still send a pause
  logic next_armed;
  logic pause_sent; // a pause went out this excursion
  logic next_pause_sent;
  logic next_pause_req;
  logic next_pause_zero;
  logic next_jam;

  assign wr_cmd = reg_sel && reg_wr && (reg_addr == `OFS_INDIRECT_CMD);
  assign wr_data = reg_sel && reg_wr && (reg_addr == `OFS_INDIRECT_DATA);
  assign wr_cfg = reg_sel && reg_wr && (reg_addr == `OFS_FLOW_CFG);
  assign acc_start = wr_cmd && reg_wdata[`CMD_BUSY_BIT] && !acc_busy;

  // indirect access sequencer
  indirect_access u_access (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(acc_start),
    .mac_done(mac_csr_done),
    .busy(acc_busy),
    .mac_req(acc_req)
  );

  // register next values: writes, read capture and read mux
  always_comb begin
    next_cfg = cfg;
    next_data = data;
    next_cmd_dir = cmd_dir;
    next_cmd_addr = cmd_addr;
    if (wr_cfg) begin
      next_cfg = reg_wdata[23:0] & 24'(`CFG_WR_MASK);
    end
    // command and data writes ignored while busy
    if (wr_cmd && !acc_busy) begin
      next_cmd_dir = reg_wdata[`CMD_DIR_BIT];
      next_cmd_addr = reg_wdata[7:0];
    end
    if (wr_data && !acc_busy) begin
      next_data = reg_wdata;
    end
    if (acc_busy && mac_csr_done && cmd_dir) begin
      next_data = mac_csr_rdata;
    end
    // read mux; unmapped offsets read zero
    case (reg_addr)
      `OFS_INDIRECT_CMD:
        next_rdata = {acc_busy, cmd_dir, 22'h00_0000, cmd_addr};
      `OFS_INDIRECT_DATA: next_rdata = data;
      `OFS_FLOW_CFG: next_rdata = {8'h00, cfg};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // register storage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= `CFG_RESET;
      data <= `DATA_RESET;
      cmd_dir <= 1'b0;
      cmd_addr <= 8'h00;
      reg_rdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      data <= next_data;
      cmd_dir <= next_cmd_dir;
      cmd_addr <= next_cmd_addr;
      reg_rdata <= next_rdata;
    end
  end

  assign mac_csr_addr = cmd_addr;
  assign mac_csr_read = cmd_dir;
  assign mac_csr_wdata = data;
  assign mac_csr_req = acc_req;

  assign hi_bytes = {cfg[`CFG_HI_MSB:`CFG_HI_LSB], 6'h00};
  assign lo_bytes = {cfg[`CFG_LO_MSB:`CFG_LO_LSB], 6'h00};
  assign at_high = (rx_fifo_bytes >= hi_bytes);
  assign below_low = (rx_fifo_bytes < lo_bytes);
  assign any_frame = cfg[`CFG_ANY_BIT];
  // frame selection for half-duplex jamming
  always_comb begin
    if (any_frame) begin
      frame_match = rx_preamble;
    end else begin
      frame_match = rx_addr_valid &&
        ((cfg[`CFG_MULT_BIT] && rx_is_multicast) ||
         (cfg[`CFG_BRD_BIT] && rx_is_broadcast) ||
         (cfg[`CFG_ADD_BIT] && rx_is_own));
    end
  end

  assign jam_start = tx_enabled && !full_duplex && at_high &&
    frame_match && !jam_running;

  // backpressure interval timer
  jam_timer u_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(jam_start),
    .code(cfg[`CFG_DUR_MSB:`CFG_DUR_LSB]),
    .slow_link(slow_link),
    .running(jam_running)
  );

  // flow machine next state
  always_comb begin
    next_state = state;
    next_armed = armed;
    next_pause_sent = pause_sent;
    next_pause_req = pause_req;
    next_pause_zero = pause_zero;
    next_jam = (jam_running || jam_start) && tx_enabled && !full_duplex;
    // a pending request ends when the mac accepts it
    if (pause_req && pause_ack) begin
      next_pause_req = 1'b0;
    end
    case (state)
      flow_pkg::idle_s: begin
        if (full_duplex && any_frame && tx_enabled && at_high &&
            armed && !pause_req) begin
          next_pause_req = 1'b1;
          next_pause_zero = 1'b0;
          next_armed = 1'b0;
          next_pause_sent = 1'b1;
          next_state = flow_pkg::paused_s;
        end else if (!full_duplex && at_high) begin
          next_state = flow_pkg::jamming_s;
        end
      end
      flow_pkg::paused_s: begin
        // resume only after a sent pause
        if (below_low && !pause_req) begin
          if (pause_sent && tx_enabled && any_frame) begin
            next_pause_req = 1'b1;
            next_pause_zero = 1'b1;
          end
          next_pause_sent = 1'b0;
          next_armed = 1'b1;
          next_state = flow_pkg::idle_s;
        end
      end
      flow_pkg::jamming_s: begin
        // half-duplex excursion ends below low
        if (below_low || full_duplex) begin
          next_state = flow_pkg::idle_s;
        end
      end
      default: next_state = flow_pkg::idle_s;
    endcase
    // no pause while transmitter is off
    if (!tx_enabled) begin
      next_pause_req = 1'b0;
    end
  end

  // flow machine registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= flow_pkg::idle_s;
      armed <= 1'b1;
      pause_sent <= 1'b0;
      pause_req <= 1'b0;
      pause_zero <= 1'b0;
      jam <= 1'b0;
    end else begin
      state <= next_state;
      armed <= next_armed;
      pause_sent <= next_pause_sent;
      pause_req <= next_pause_req;
      pause_zero <= next_pause_zero;
      jam <= next_jam;
    end
  end
endmodule

// file: flow_consts.svh
// constant offsets, fields, reset values and timing counts for the flow
// controller; included by the design files, holds definitions only
`ifndef FLOW_CONSTS_SVH
`define FLOW_CONSTS_SVH
`define OFS_INDIRECT_CMD 8'hA4
`define OFS_INDIRECT_DATA 8'hA8
`define OFS_FLOW_CFG 8'hAC
`define CMD_BUSY_BIT 31
`define CMD_DIR_BIT 30
`define CFG_HI_MSB 23
`define CFG_HI_LSB 16
`define CFG_LO_MSB 15
`define CFG_LO_LSB 8
`define CFG_DUR_MSB 7
`define CFG_DUR_LSB 4
`define CFG_MULT_BIT 3
`define CFG_BRD_BIT 2
`define CFG_ADD_BIT 1
`define CFG_ANY_BIT 0
`define DATA_RESET 32'h0000_0000
`define CFG_RESET 24'h00_0000
`define CFG_WR_MASK 32'h00FF_FFFF
`define CLK_MHZ 100
`define DUR_STEP_NS 50000
`define DUR_SLOW_EXTRA_NS 2200
`define UNIT_SHIFT 6
`endif

// file: flow_pkg.sv
// types shared by the flow controller design files
// assumes flow_consts.svh gives the numeric values
package flow_pkg;
  // states of the automatic flow machine
  typedef enum logic [1:0] {
    idle_s,
    paused_s,
    jamming_s
  } flow_state_t;
  // states of the indirect mac register access
  typedef enum logic [1:0] {
    acc_idle_s,
    acc_wait_s
  } acc_state_t;
endpackage

// file: jam_timer.sv
// jam_timer: counts down one backpressure interval from a duration code
// assumes a 100 MHz clock and a speed flag from the mac
`timescale 1ns/1ps
`include "flow_consts.svh"
module jam_timer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [3:0] code,
  input wire logic slow_link,
  output logic running
);
  logic [16:0] count; // cycles left in the interval
  logic [16:0] next_count;
  logic [16:0] load; // interval length in cycles
  // duration table: codes 0..3 special, then 50 us steps
  always_comb begin
    case (code)
      4'h0: load = 17'(5000 * `CLK_MHZ / 1000);
      4'h1: load = 17'(10000 * `CLK_MHZ / 1000);
      4'h2: load = 17'(15000 * `CLK_MHZ / 1000);
      4'h3: load = 17'(25000 * `CLK_MHZ / 1000);
      default: load = 17'((32'(code) - 32'd3) * `DUR_STEP_NS
                          * `CLK_MHZ / 1000);
    endcase
    // the 10 Mb/s interval is 2.2 us longer
    if (slow_link) begin
      load = load + 17'(`DUR_SLOW_EXTRA_NS * `CLK_MHZ / 1000);
    end
  end
  // next count: load on start, else count to zero
  always_comb begin
    if (start) begin
      // the start edge itself is the first jam cycle
      next_count = load - 17'h0_0001;
    end else if (count != 17'h0_0000) begin
      next_count = count - 17'h0_0001;
    end else begin
      next_count = count;
    end
  end
  // registered count and running flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 17'h0_0000;
    end else begin
      count <= next_count;
    end
  end
  assign running = (count != 17'h0_0000);
endmodule

// file: indirect_access.sv
// indirect_access: sequences one indirect mac register read or write
// assumes the mac answers each request with a one-cycle done pulse
`timescale 1ns/1ps
`include "flow_consts.svh"
module indirect_access (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic mac_done,
  output logic busy,
  output logic mac_req
);
  flow_pkg::acc_state_t state; // access sequencer
  flow_pkg::acc_state_t next_state;
  logic next_req;
  // next state: request once, then wait for the done pulse
  always_comb begin
    next_state = state;
    next_req = 1'b0;
    case (state)
      flow_pkg::acc_idle_s: begin
        if (start) begin
          next_state = flow_pkg::acc_wait_s;
          next_req = 1'b1;
        end
      end
      flow_pkg::acc_wait_s: begin
        if (mac_done) begin
          next_state = flow_pkg::acc_idle_s;
        end
      end
      default: next_state = flow_pkg::acc_idle_s;
    endcase
  end
  // registered sequencer state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= flow_pkg::acc_idle_s;
      mac_req <= 1'b0;
    end else begin
      state <= next_state;
      mac_req <= next_req;
    end
  end
  assign busy = (state == flow_pkg::acc_wait_s);
endmodule

// file: mac_model.sv
// mac side model: acks pause requests, answers indirect accesses
// assumes one outstanding request of each kind
`timescale 1ns/1ps
module mac_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] lat,
  input wire logic [31:0] rd_value,
  input wire logic pause_req,
  output logic pause_ack,
  input wire logic mac_csr_req,
  output logic mac_csr_done,
  output logic [31:0] mac_csr_rdata
);
  logic [3:0] pcnt, ccnt;
  logic cbusy;
  // data is valid only with done, its inverse otherwise
  assign mac_csr_rdata = mac_csr_done ? rd_value : ~rd_value;
  // ack a pause lat+1 cycles, and finish an access lat+2 cycles, after the request rises
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pause_ack <= 1'b0;
      mac_csr_done <= 1'b0;
      pcnt <= 4'h0;
      ccnt <= 4'h0;
      cbusy <= 1'b0;
    end else begin
      pause_ack <= 1'b0;
      mac_csr_done <= 1'b0;
      if (pause_req && !pause_ack) begin
        pcnt <= pcnt + 4'h1;
        if (pcnt >= lat) begin
          pause_ack <= 1'b1;
          pcnt <= 4'h0;
        end
      end
      if (mac_csr_req) begin
        cbusy <= 1'b1;
        ccnt <= 4'h0;
      end else if (cbusy) begin
        ccnt <= ccnt + 4'h1;
        if (ccnt >= lat) begin
          mac_csr_done <= 1'b1;
          cbusy <= 1'b0;
        end
      end
    end
  end
endmodule

// file: flow_check_properties.sv
// port checker for rx_fifo_flow_control
// assumes config and command change only through the register port
`timescale 1ns/1ps
module flow_check (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [13:0] rx_fifo_bytes,
  input wire logic full_duplex,
  input wire logic tx_enabled,
  input wire logic rx_preamble,
  input wire logic rx_addr_valid,
  input wire logic pause_req,
  input wire logic pause_zero,
  input wire logic pause_ack,
  input wire logic jam,
  input wire logic mac_csr_req,
  input wire logic mac_csr_read,
  input wire logic [7:0] mac_csr_addr
);
  logic [23:0] cfg;
  logic [8:0] cmd;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // shadow copies of config and command writes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= 24'h000000;
      cmd <= 9'h000;
    end else if (reg_sel && reg_wr) begin
      if (reg_addr == 8'hAC) cfg <= reg_wdata[23:0];
      if (reg_addr == 8'hA4 && reg_wdata[31]) begin
        cmd <= {reg_wdata[30], reg_wdata[7:0]};
      end
    end
  end
  property p_hold; pause_req && !pause_ack |=> pause_req; endproperty
  a_hold: assert property (p_hold) else $error("pause dropped");
  property p_hi;
    $rose(pause_req) && !pause_zero |->
      $past(rx_fifo_bytes) >= {cfg[23:16], 6'h00};
  endproperty
  a_hi: assert property (p_hi) else $error("pause below high");
  property p_lo;
    $rose(pause_req) && pause_zero |->
      $past(rx_fifo_bytes) < {cfg[15:8], 6'h00};
  endproperty
  a_lo: assert property (p_lo) else $error("resume not low");
  property p_tx; $rose(pause_req) || $rose(jam) |-> $past(tx_enabled);
  endproperty
  a_tx: assert property (p_tx) else $error("tx off action");
  property p_fd; $rose(jam) |-> !$past(full_duplex); endproperty
  a_fd: assert property (p_fd) else $error("jam in full");
  property p_frame;
    $rose(jam) |-> $past(rx_preamble) || $past(rx_addr_valid);
  endproperty
  a_frame: assert property (p_frame) else $error("jam no frame");
  property p_dur; $rose(jam) |-> jam [*8]; endproperty
  a_dur: assert property (p_dur) else $error("jam short");
  property p_any; $rose(pause_req) |-> cfg[0]; endproperty
  a_any: assert property (p_any) else $error("pause no enable");
  property p_req; mac_csr_req |=> !mac_csr_req; endproperty
  a_req: assert property (p_req) else $error("req long");
  property p_cmd;
    mac_csr_req |-> mac_csr_read == cmd[8] && mac_csr_addr == cmd[7:0];
  endproperty
  a_cmd: assert property (p_cmd) else $error("bad cmd");
endmodule
bind rx_fifo_flow_control flow_check i_check (.ref_clk(ref_clk),
  .nrst(nrst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .rx_fifo_bytes(rx_fifo_bytes),
  .full_duplex(full_duplex), .tx_enabled(tx_enabled),
  .rx_preamble(rx_preamble), .rx_addr_valid(rx_addr_valid),
  .pause_req(pause_req), .pause_zero(pause_zero), .pause_ack(pause_ack),
  .jam(jam), .mac_csr_req(mac_csr_req), .mac_csr_read(mac_csr_read),
  .mac_csr_addr(mac_csr_addr));

// file: rx_fifo_flow_control_test.sv
// bench for rx_fifo_flow_control
// assumes mac_model on the far side and a 100 MHz clock
`timescale 1ns/1ps
`include "flow_consts.svh"
module rx_fifo_flow_control_test;
  logic ref_clk = 0, nrst = 0, reg_sel = 0, reg_wr = 0, full_duplex = 0;
  logic slow_link = 0, tx_enabled = 0, rx_preamble = 0, rx_addr_valid = 0;
  logic rx_is_multicast = 0, rx_is_broadcast = 0, rx_is_own = 0;
  logic pause_req, pause_zero, pause_ack, jam, mac_csr_req, mac_csr_read;
  logic mac_csr_done;
  logic [7:0] reg_addr = 0, mac_csr_addr;
  logic [31:0] reg_wdata = 0, reg_rdata, mac_csr_wdata, mac_csr_rdata, d;
  logic [13:0] rx_fifo_bytes = 0;
  logic [3:0] lat = 4'h0;
  int mismatches = 0, checked = 0, cyc = 0, acks = 0, n;
  rx_fifo_flow_control i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_fifo_bytes(rx_fifo_bytes), .full_duplex(full_duplex),
    .slow_link(slow_link), .tx_enabled(tx_enabled),
    .rx_preamble(rx_preamble), .rx_addr_valid(rx_addr_valid),
    .rx_is_multicast(rx_is_multicast), .rx_is_broadcast(rx_is_broadcast),
    .rx_is_own(rx_is_own), .pause_req(pause_req), .pause_zero(pause_zero),
    .pause_ack(pause_ack), .jam(jam), .mac_csr_req(mac_csr_req),
    .mac_csr_read(mac_csr_read), .mac_csr_addr(mac_csr_addr),
    .mac_csr_wdata(mac_csr_wdata), .mac_csr_rdata(mac_csr_rdata),
    .mac_csr_done(mac_csr_done));
  mac_model i_mac (.ref_clk(ref_clk), .nrst(nrst), .lat(lat),
    .rd_value(32'hC0DE_F00D), .pause_req(pause_req), .pause_ack(pause_ack),
    .mac_csr_req(mac_csr_req), .mac_csr_done(mac_csr_done),
    .mac_csr_rdata(mac_csr_rdata));
  always #5 ref_clk = ~ref_clk;
  // count pause frames taken and cut a hang short
  always @(posedge ref_clk) begin
    if (pause_ack === 1'b1) acks++;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize;
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_sel <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_sel <= 1'b0;
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    tick(1);
    d = reg_rdata;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return pause_req;
      1: return mac_csr_req;
      default: return mac_csr_done;
    endcase
  endfunction
  task automatic wfor(input int k);
    int i;
    i = 0;
    // let the launching edge settle before looking
    #1;
    while (sig(k) !== 1'b1 && i < 50) begin
      tick(1);
      i++;
    end
    chk(sig(k), 1'b1);
  endtask
  // drive one frame pulse, return how long jam then stands
  task automatic frame(input logic p, a, m, b, o);
    @(posedge ref_clk);
    {rx_preamble, rx_addr_valid} <= {p, a};
    {rx_is_multicast, rx_is_broadcast, rx_is_own} <= {m, b, o};
    @(posedge ref_clk);
    {rx_preamble, rx_addr_valid} <= 2'b00;
    #1;
    n = 0;
    while (jam === 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic t_regs;
    rd(`OFS_INDIRECT_DATA);
    chk(d, 32'h0000_0000);
    rd(`OFS_FLOW_CFG);
    chk(d, 32'h0000_0000);
    wr(`OFS_FLOW_CFG, 32'hFFFF_FFFF);
    rd(`OFS_FLOW_CFG);
    chk(d, 32'h00FF_FFFF);
    wr(`OFS_INDIRECT_DATA, 32'hA5C3_0F96);
    rd(`OFS_INDIRECT_DATA);
    chk(d, 32'hA5C3_0F96);
    rd(8'h10);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_indirect;
    lat = 4'h6;
    wr(`OFS_INDIRECT_DATA, 32'h1234_5678);
    wr(`OFS_INDIRECT_CMD, 32'h8000_005A);
    wfor(1);
    chk({mac_csr_read, mac_csr_addr}, 32'h05A);
    chk(mac_csr_wdata, 32'h1234_5678);
    rd(`OFS_INDIRECT_CMD);
    chk(d[31], 1'b1);
    wfor(2);
    rd(`OFS_INDIRECT_CMD);
    chk(d[31], 1'b0);
    wr(`OFS_INDIRECT_CMD, 32'hC000_0033);
    wfor(1);
    chk({mac_csr_read, mac_csr_addr}, 32'h133);
    wfor(2);
    rd(`OFS_INDIRECT_DATA);
    chk(d, 32'hC0DE_F00D);
    lat = 4'h0;
  endtask
  task automatic t_full;
    {full_duplex, tx_enabled, rx_fifo_bytes} <= {2'b11, 14'd255};
    wr(`OFS_FLOW_CFG, 32'h0004_02F1);
    tick(5);
    chk(pause_req, 1'b0);
    rx_fifo_bytes <= 14'd256;
    wfor(0);
    chk(pause_zero, 1'b0);
    tick(20);
    chk(acks, 1);
    rx_fifo_bytes <= 14'd128;
    tick(10);
    chk(acks, 1);
    rx_fifo_bytes <= 14'd127;
    wfor(0);
    chk(pause_zero, 1'b1);
    tick(5);
    {tx_enabled, rx_fifo_bytes} <= {1'b0, 14'd300};
    tick(20);
    rx_fifo_bytes <= 14'd0;
    tick(10);
    tx_enabled <= 1'b1;
    tick(20);
    chk(acks, 2);
    wr(`OFS_FLOW_CFG, 32'h0004_020E);
    rx_fifo_bytes <= 14'd300;
    frame(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    tick(20);
    chk(acks, 2);
    chk(n, 0);
    rx_fifo_bytes <= 14'd0;
  endtask
  task automatic t_half;
    full_duplex <= 1'b0;
    wr(`OFS_FLOW_CFG, 32'h0004_0002);
    rx_fifo_bytes <= 14'd256;
    frame(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk(n, 0);
    frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    chk(n, 500);
    slow_link <= 1'b1;
    frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    chk(n, 720);
    slow_link <= 1'b0;
    wr(`OFS_FLOW_CFG, 32'h0004_0018);
    frame(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk(n, 1000);
    wr(`OFS_FLOW_CFG, 32'h0004_0001);
    frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(n, 500);
    chk(acks, 2);
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs;
    t_indirect;
    t_full;
    t_half;
    summarize;
  end
endmodule
